// ==== shared/fllc_pkg.sv ====
// constants shared by the frequency-locked loop control block
// assumes a 32-bit APB master on pclk
package fllc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  ADDR_CTRL1  = 8'h80;
  localparam logic [7:0]  ADDR_CTRL2  = 8'h84;
  localparam logic [7:0]  ADDR_MULT_N = 8'h88;
  localparam logic [7:0]  ADDR_MULT_K = 8'h8C;
  localparam logic [7:0]  ADDR_STATUS = 8'h90;
  // ****************************************
  // field positions
  // ****************************************
  localparam int ENA_BIT    = 0;
  localparam int FRAC_BIT   = 2;
  localparam int HOLD_BIT   = 3;
  localparam int GAIN_LSB   = 4;
  localparam int FRATIO_LSB = 0;
  localparam int OUTDIV_LSB = 3;
  localparam int RATE_LSB   = 6;
  localparam int PREDIV_LSB = 9;
  localparam int SRC_LSB    = 11;
  // ****************************************
  // reset values and codes
  // ****************************************
  localparam logic [15:0] CTRL1_RST  = 16'h0000;
  localparam logic [15:0] CTRL2_RST  = 16'h0000;
  localparam logic [9:0]  MULT_N_RST = 10'h000;
  localparam logic [15:0] MULT_K_RST = 16'h0000;
  localparam logic [1:0]  SRC_MASTER = 2'h0;
  localparam logic [1:0]  SRC_BIT    = 2'h1;
  localparam logic [1:0]  SRC_FRAME  = 2'h2;
  localparam logic [2:0]  FRATIO_MAX = 3'h4;
  localparam logic [3:0]  GAIN_MAX   = 4'h8;
  localparam int          ERR_SHIFT  = 20;
  localparam int          REF_LOSS_CYCLES = 2048;
  typedef enum logic [1:0] {
    LOOP_OFF  = 2'b00,
    LOOP_ACQ  = 2'b01,
    LOOP_RUN  = 2'b11,
    LOOP_HOLD = 2'b10
  } fllc_state_t;
endpackage

// ==== src/fllc_core.sv ====
// digital frequency-locked loop control with APB register access
// assumes reference pins are asynchronous to pclk and slower than pclk / 4
//
// Contract
// [RL1] source select picks master, bit or frame clock input as reference
// [RL2] chosen reference is divided by 1, 2, 4 or 8 before the loop
// [RL3] software keeps the divided reference at or below 13.5 MHz
// [RL4] software clears enable before changing settings, sets it last
// [RL5] clearing enable resets the loop; do so when reference changes
// [RL6] multiplier is integer part plus fraction whose top bit weighs half
// [RL7] fraction applies only in fractional mode; integer mode uses integer part
// [RL8] oscillator runs at multiplier times ratio times reference; output divided
// [RL9] software keeps oscillator frequency within 90 to 100 MHz
// [RL10] software picks output divider code from the wanted output frequency
// [RL11] software picks reference ratio code from the effective reference
// [RL12] fraction field equals fraction times 65536, rounded
// [RL13] software prefers fractional mode with a non-integer multiplier
// [RL14] integer mode only when fraction is zero, by clearing fractional bit
// [RL15] error gain is two to the power of field bits 7:4, up to 256
// [RL16] software leaves the control rate field at its default
// [RL17] device keeps a free-running output clock without a reference
// [RL18] with hold select set, reference loss enters free-running mode
// [RL19] fractional mode is bit 2, loop enable bit 0
// [RL20] reference divide field bits 10:9 code divide by 1, 2, 4, 8
//
// Register access over APB was left to the implementer.
module fllc_core #(
  parameter int          REF_LOSS = fllc_pkg::REF_LOSS_CYCLES,
  parameter logic [31:0] INC_INIT = 32'hF000_0000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_clock_input,
  input  wire logic        bit_clock_input,
  input  wire logic        frame_clock_input,
  output logic             system_clock,
  output logic             loop_running,
  output logic             loop_free_running
);
  import fllc_pkg::*;

  // ****************************************
  // register file
  // ****************************************
  logic [15:0] ctrl1_r, ctrl2_r, mult_k_r;
  logic [9:0]  mult_n_r;
  logic [31:0] prdata_r;
  logic        pready_r, pslverr_r;
  fllc_state_t state_r, state_nxt;

  wire       setup_ph  = psel && !penable && !pready_r;
  wire       wr_done   = psel && penable && pready_r && pwrite;
  wire       hit_c1    = (paddr == ADDR_CTRL1);
  wire       hit_c2    = (paddr == ADDR_CTRL2);
  wire       hit_n     = (paddr == ADDR_MULT_N);
  wire       hit_k     = (paddr == ADDR_MULT_K);
  wire       hit_st    = (paddr == ADDR_STATUS);
  wire       mapped    = hit_c1 || hit_c2 || hit_n || hit_k || hit_st;
  wire [31:0] rd_mux   = hit_c1 ? {16'h0000, ctrl1_r} :
                         hit_c2 ? {16'h0000, ctrl2_r} :
                         hit_n  ? {22'h0, mult_n_r} :
                         hit_k  ? {16'h0000, mult_k_r} :
                         hit_st ? {30'h0, state_r} : 32'h0000_0000;

  // [RL19] enable and fractional bits
  wire       loop_enable            = ctrl1_r[ENA_BIT];
  wire       fractional_mode_select = ctrl1_r[FRAC_BIT];
  wire       hold_select            = ctrl1_r[HOLD_BIT];
  wire [3:0] loop_error_gain        = ctrl1_r[GAIN_LSB +: 4];
  wire [2:0] reference_ratio_divisor = ctrl2_r[FRATIO_LSB +: 3];
  wire [2:0] output_divider         = ctrl2_r[OUTDIV_LSB +: 3];
  wire [2:0] loop_control_rate      = ctrl2_r[RATE_LSB +: 3];
  // [RL20] predivide field
  wire [1:0] reference_predivide    = ctrl2_r[PREDIV_LSB +: 2];
  wire [1:0] reference_source_select = ctrl2_r[SRC_LSB +: 2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_r   <= CTRL1_RST;
      ctrl2_r   <= CTRL2_RST;
      mult_n_r  <= MULT_N_RST;
      mult_k_r  <= MULT_K_RST;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph && !mapped;
      if (setup_ph) prdata_r <= rd_mux;
      // bits 15:8 and 1 stay zero
      if (wr_done && hit_c1) ctrl1_r <= {8'h00, pwdata[7:2], 1'b0, pwdata[0]};
      if (wr_done && hit_c2) ctrl2_r <= {3'h0, pwdata[12:0]};
      if (wr_done && hit_n) mult_n_r <= pwdata[9:0];
      if (wr_done && hit_k) mult_k_r <= pwdata[15:0];
    end
  end
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************
  // reference selection and predivide
  // ****************************************
  logic [2:0] ref_s1_r, ref_s2_r;
  logic       ref_d_r;
  logic [2:0] pre_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_s1_r <= 3'h0;
      ref_s2_r <= 3'h0;
    end else if (ce) begin
      ref_s1_r <= {frame_clock_input, bit_clock_input, master_clock_input};
      ref_s2_r <= ref_s1_r;
    end
  end
  // [RL1] three-way reference mux
  wire       ref_sel   = (reference_source_select == SRC_MASTER) ? ref_s2_r[0] :
                         (reference_source_select == SRC_BIT)    ? ref_s2_r[1] :
                         (reference_source_select == SRC_FRAME)  ? ref_s2_r[2] : 1'b0;
  wire       ref_rise  = ref_sel && !ref_d_r;
  wire [2:0] pre_last  = 3'((1 << reference_predivide) - 1);
  // [RL2] effective reference pulse every 1, 2, 4 or 8 edges
  wire       ref_tick  = ref_rise && (pre_cnt_r == pre_last);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d_r   <= 1'b0;
      pre_cnt_r <= 3'h0;
    end else if (ce) begin
      ref_d_r <= ref_sel;
      if (!loop_enable) pre_cnt_r <= 3'h0;
      else if (ref_rise) pre_cnt_r <= ref_tick ? 3'h0 : pre_cnt_r + 3'h1;
    end
  end

  // ****************************************
  // loop state and oscillator
  // ****************************************
  logic [31:0] inc_r, acc_r;
  logic [15:0] vco_cnt_r;
  logic [15:0] loss_cnt_r;
  logic [2:0]  rate_cnt_r;
  logic [7:0]  out_cnt_r;
  logic        sysclk_r;
  wire         ref_lost  = (loss_cnt_r >= 16'(REF_LOSS));
  wire         vco_on    = (state_r == LOOP_RUN) || (state_r == LOOP_HOLD);
  wire [32:0]  acc_sum   = {1'b0, acc_r} + {1'b0, inc_r};
  wire         vco_tick  = vco_on && acc_sum[32];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LOOP_OFF:  if (loop_enable) state_nxt = LOOP_ACQ;
      LOOP_ACQ:  if (ref_tick) state_nxt = LOOP_RUN;
      // [RL18] hold keeps the oscillator alive on loss
      LOOP_RUN:  if (ref_lost) state_nxt = hold_select ? LOOP_HOLD : LOOP_ACQ;
      LOOP_HOLD: if (ref_tick) state_nxt = LOOP_RUN;
      default:   state_nxt = LOOP_OFF;
    endcase
    // [RL5] clearing enable resets the loop
    if (!loop_enable) state_nxt = LOOP_OFF;
  end

  // [RL6] integer lsb weighs one, fraction msb weighs half
  // [RL7] fraction masked in integer mode
  // [RL14] integer mode ignores fraction
  wire [25:0] nk        = {mult_n_r, fractional_mode_select ? mult_k_r : 16'h0000};
  wire [2:0]  fr_shift  = (reference_ratio_divisor > FRATIO_MAX) ? FRATIO_MAX
                                                                 : reference_ratio_divisor;
  // [RL8] target oscillator ticks per reference period
  wire [31:0] target    = {6'h00, nk} << fr_shift;
  wire [31:0] measured  = {vco_cnt_r, 16'h0000};
  wire signed [31:0] err      = $signed(target - measured);
  wire [3:0]  gain_sh   = (loop_error_gain > GAIN_MAX) ? GAIN_MAX : loop_error_gain;
  // [RL15] error scaled by two to the gain code
  wire signed [31:0] step     = (err >>> ERR_SHIFT) <<< gain_sh;
  wire        do_update = ref_tick && (state_r == LOOP_RUN) && (rate_cnt_r == loop_control_rate);
  wire [7:0]  out_last  = 8'((1 << output_divider) - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r    <= LOOP_OFF;
      inc_r      <= INC_INIT;
      acc_r      <= 32'h0000_0000;
      vco_cnt_r  <= 16'h0000;
      loss_cnt_r <= 16'h0000;
      rate_cnt_r <= 3'h0;
      out_cnt_r  <= 8'h00;
      sysclk_r   <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (!loop_enable) begin
        inc_r      <= INC_INIT;
        acc_r      <= 32'h0000_0000;
        vco_cnt_r  <= 16'h0000;
        loss_cnt_r <= 16'h0000;
        rate_cnt_r <= 3'h0;
        out_cnt_r  <= 8'h00;
        sysclk_r   <= 1'b0;
      end else begin
        if (vco_on) acc_r <= acc_sum[31:0];
        loss_cnt_r <= ref_tick ? 16'h0000 : (ref_lost ? loss_cnt_r : loss_cnt_r + 16'h0001);
        if (ref_tick) begin
          vco_cnt_r  <= 16'(vco_tick);
          rate_cnt_r <= (rate_cnt_r == loop_control_rate) ? 3'h0 : rate_cnt_r + 3'h1;
        end else if (vco_tick && vco_cnt_r != 16'hFFFF) begin
          vco_cnt_r <= vco_cnt_r + 16'h0001;
        end
        if (do_update) inc_r <= inc_r + 32'(step);
        // [RL17] output keeps toggling while free-running
        if (vco_tick) begin
          out_cnt_r <= (out_cnt_r == out_last) ? 8'h00 : out_cnt_r + 8'h01;
          if (out_cnt_r == out_last) sysclk_r <= !sysclk_r;
        end
        if (!vco_on) sysclk_r <= 1'b0;
      end
    end
  end

  logic run_r, free_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r  <= 1'b0;
      free_r <= 1'b0;
    end else if (ce) begin
      run_r  <= (state_nxt == LOOP_RUN);
      free_r <= (state_nxt == LOOP_HOLD);
    end
  end
  assign system_clock      = sysclk_r;
  assign loop_running      = run_r;
  assign loop_free_running = free_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  src_select_a: assert property (ce && reference_source_select == SRC_FRAME |->
    ref_sel == ref_s2_r[2]) else $error("reference mux wrong"); // [RL1]
  prediv_tick_a: assert property (ce && ref_tick |-> pre_cnt_r == pre_last && ref_rise)
    else $error("predivide tick wrong"); // [RL2]
  ena_reset_a: assert property (ce && !loop_enable |=> state_r == LOOP_OFF && !vco_on)
    else $error("loop not reset"); // [RL5]
  int_mode_a: assert property (!fractional_mode_select |-> nk[15:0] == 16'h0000)
    else $error("fraction used in integer mode"); // [RL7]
  frac_weight_a: assert property (fractional_mode_select && fr_shift == 3'h0 |->
    target == {6'h00, mult_n_r, mult_k_r}) else $error("multiplier weights wrong"); // [RL6]
  ratio_scale_a: assert property (fr_shift == 3'h1 |-> target == {5'h00, nk, 1'b0})
    else $error("ratio scaling wrong"); // [RL8]
  gain_step_a: assert property (ce && do_update && loop_enable |=>
    inc_r == $past(inc_r) + 32'($past(step))) else $error("gain step not applied"); // [RL15]
  hold_enter_a: assert property (ce && loop_enable && state_r == LOOP_RUN && ref_lost &&
    hold_select |=> state_r == LOOP_HOLD) else $error("hold not entered"); // [RL18]
  no_hold_a: assert property (ce && loop_enable && state_r == LOOP_RUN && ref_lost &&
    !hold_select |=> state_r == LOOP_ACQ ##1 !sysclk_r) else $error("lost loop kept clock"); // [RL18]
  bit_pos_a: assert property (ce && wr_done && hit_c1 |=>
    loop_enable == $past(pwdata[0]) && fractional_mode_select == $past(pwdata[2]))
    else $error("control bits misplaced"); // [RL19]
  free_run_c: cover property (state_r == LOOP_RUN ##1 state_r == LOOP_HOLD);
  lock_run_c: cover property (state_r == LOOP_ACQ ##1 state_r == LOOP_RUN);
  update_c:   cover property (do_update && fractional_mode_select);
endmodule

// ==== tb/fllc_ref_src.sv ====
// reference clock source model driving the three reference pins
// assumes pclk at 100 MHz; every pin stands low between bursts
module fllc_ref_src (
  input  wire logic pclk,
  output logic      master_clock_input,
  output logic      bit_clock_input,
  output logic      frame_clock_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pins = 3'h0;
  assign master_clock_input = pins[0];
  assign bit_clock_input    = pins[1];
  assign frame_clock_input  = pins[2];
  // ****************************************
  // edge bursts
  // ****************************************
  // 12.5 MHz reference
  // eight-cycle period stays under the divided-reference limit
  task automatic edges(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      pins[sel] <= 1'b1;
      repeat (4) @(posedge pclk);
      pins[sel] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the loop control block with an APB master
// assumes the reference source model and the shared package are compiled first
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fllc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, w;
  logic        pready, pslverr, mck, bck, fck, sys_clk, l_run, l_free, sc_q;
  int          bad_count = 0, n_tests = 0, cyc = 0, tog = 0, s, t0;
  logic [7:0]  ra [4] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_MULT_N, ADDR_MULT_K};
  logic [31:0] rm [4] = '{32'h00FD, 32'h1FFF, 32'h03FF, 32'hFFFF};
  // register model: last written value under each read mask
  logic [31:0] mdl [4] = '{32'(CTRL1_RST), 32'(CTRL2_RST), 32'(MULT_N_RST), 32'(MULT_K_RST)};

  fllc_core #(.REF_LOSS(64)) fllc_core_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_clock_input(mck), .bit_clock_input(bck),
    .frame_clock_input(fck), .system_clock(sys_clk), .loop_running(l_run),
    .loop_free_running(l_free));
  fllc_ref_src fllc_ref_src_i (
    .pclk(pclk), .master_clock_input(mck), .bit_clock_input(bck), .frame_clock_input(fck));

  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    sc_q <= sys_clk;
    if (sys_clk !== sc_q) tog <= tog + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // waits for the answer; the cycle ceiling ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    foreach (ra[j]) begin
      if (ra[j] == a) mdl[j] = d & rm[j];
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic ee = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK({e, r}, {ee, exp})
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(76));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[i]) rd_chk(ra[i], 32'h0);
    rd_chk(ADDR_STATUS, 32'h0);
    foreach (ra[i]) begin
      w = $urandom() & ((i == 0) ? 32'hFFFF_FFFE : 32'hFFFF_FFFF);
      wr(ra[i], w);
      rd_chk(ra[i], mdl[i]);
    end
    rd_chk(8'hA0, 32'h0, 1'b1);
    // 7.52 times 12.5 MHz, near 94 MHz
    wr(ADDR_MULT_N, 32'd7);
    wr(ADDR_MULT_K, 32'h851F);
    for (int p = 0; p < 4; p++) begin
      s = p % 3;
      wr(ADDR_CTRL2, (s << SRC_LSB) | (p << PREDIV_LSB) | (1 << OUTDIV_LSB));
      wr(ADDR_CTRL1, 32'h5);
      fllc_ref_src_i.edges((s + 1) % 3, 8);
      rd_chk(ADDR_STATUS, 32'h1);
      fllc_ref_src_i.edges(s, (1 << p) - 1);
      rd_chk(ADDR_STATUS, 32'h1);
      fllc_ref_src_i.edges(s, 1);
      repeat (8) @(posedge pclk);
      `CHK(l_run, 1'b1)
      rd_chk(ADDR_STATUS, 32'h3);
      wr(ADDR_CTRL1, 32'h4);
      rd_chk(ADDR_STATUS, 32'h0);
      `CHK({l_run, sys_clk}, 2'b00)
    end
    wr(ADDR_CTRL2, 32'h3 << SRC_LSB);
    wr(ADDR_CTRL1, 32'h5);
    for (int i = 0; i < 3; i++) fllc_ref_src_i.edges(i, 2);
    rd_chk(ADDR_STATUS, 32'h1);
    wr(ADDR_CTRL1, 32'h4);
    wr(ADDR_CTRL2, 32'h1 << OUTDIV_LSB);
    for (int h = 1; h >= 0; h--) begin
      if (h == 0) wr(ADDR_MULT_K, 32'h0);
      wr(ADDR_CTRL1, 32'h1 | (h << HOLD_BIT) | (h << FRAC_BIT));
      fllc_ref_src_i.edges(0, 16);
      `CHK(l_run, 1'b1)
      repeat (150) @(posedge pclk);
      t0 = tog;
      repeat (100) @(posedge pclk);
      `CHK(l_free, h[0])
      `CHK(tog > t0, h == 1)
      if (h == 1) begin
        // clock enable low freezes the free-running output
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        t0 = tog;
        repeat (20) @(posedge pclk);
        `CHK({tog == t0, l_free}, 2'b11)
        ce <= 1'b1;
      end
      rd_chk(ADDR_STATUS, (h == 1) ? 32'h2 : 32'h1);
      wr(ADDR_CTRL1, 32'h4);
    end
    foreach (ra[i]) rd_chk(ra[i], mdl[i]);
    finish_test();
  end
endmodule
